// file: card_line_cfg.svh
// Register indices, field positions, reset values and timing counts for the card line block.
`ifndef CARD_LINE_CFG_SVH
`define CARD_LINE_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define INT_CTL_IDX 16'hfe0a
`define EXT_CTL_IDX 16'hfe0b
`define DIR_CTL_IDX 16'hfe0c
`define MODE_CTL_IDX 16'hfe0e

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define INT_AUX8_BIT 3
`define INT_AUX4_BIT 2
`define DIR_AUX8_BIT 3
`define DIR_AUX4_BIT 2
`define EXT_IO_BIT 5
`define EXT_IODIR_BIT 4
`define EXT_INTERNAL_CLOCK_IDLE_LEVEL_BIT 1
`define EXT_INTERNAL_CLOCK_DISABLE_BIT 0
`define MODE_SYNC_BIT 5
`define MODE_BYPASS_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define INT_CTL_RST 8'h00
`define EXT_CTL_RST 8'h00
`define DIR_CTL_RST 8'h0c
`define MODE_CTL_RST 8'h00

// ----------------------------------------------------------------------
// Bus answers and timing
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ETU_HALF_DEF 4

`endif

// file: card_line_ctrl.sv
// Direct control and sampling of card auxiliary, serial I/O and serial clock lines.
// Contract
// - Aux 8 output drives last written bit.
// - Aux 8 output reads stored bit.
// - Aux 8 input reads pin level.
// - Aux 8 input write stored, not driven.
// - Aux 4 output drives last written bit.
// - Aux 4 output reads stored bit.
// - Aux 4 input reads pin level.
// - Aux 4 input write stored, not driven.
// - I/O direction one reads I/O pin.
// - I/O direction zero drives written level.
// - I/O bits act only bypass/sync.
// - Sync mode captures I/O on clock rise.
// - Direction one input, zero output.
// - Stopped clock holds the level bit.
// - Bypass: level bit drives clock line.
// - Disable zero runs clock, one stops.
// - Disable ignored in bypass mode.
// - External register index fe0b, resets zero.
// - Aux directions separate, tri-stated after reset.
// - Sync mode: register I/O, divider clock.
`timescale 1ns/100ps
`include "card_line_cfg.svh"

module card_line_ctrl #(
  parameter int ADDR_W = 18,
  parameter int ETU_HALF = `ETU_HALF_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic aux8In,
  output logic aux8Out,
  output logic aux8Oe,
  input wire logic aux4In,
  output logic aux4Out,
  output logic aux4Oe,
  input wire logic sioIn,
  output logic sioOut,
  output logic sioOe,
  output logic sclkOut
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  localparam int CW = $clog2(ETU_HALF + 1);
  localparam logic [7:0] INT_RST = `INT_CTL_RST;

  generate
    if (ADDR_W < 18 || ADDR_W > 32) begin : gBadAddr
      $error("Address width must be 18 to 32.");
    end
    if (ETU_HALF < 1) begin : gBadEtu
      $error("Divider half period must be at least one.");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic card_line_pkg::regSel_t decode(
    input logic [ADDR_W-1:0] addr
  );
    logic [ADDR_W-1:0] idx;
    idx = addr >> 2;
    decode = card_line_pkg::SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      if (idx == ADDR_W'(`INT_CTL_IDX)) decode = card_line_pkg::SEL_INT;
      if (idx == ADDR_W'(`EXT_CTL_IDX)) decode = card_line_pkg::SEL_EXT;
      if (idx == ADDR_W'(`DIR_CTL_IDX)) decode = card_line_pkg::SEL_DIR;
      if (idx == ADDR_W'(`MODE_CTL_IDX)) decode = card_line_pkg::SEL_MODE;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Pins are asynchronous to clk, so every level is taken through two
  // flip-flops; a read shows the pin at least two cycles late.
  logic aux8Meta_reg, aux8Sync_reg;
  logic aux4Meta_reg, aux4Sync_reg;
  logic sioMeta_reg, sioSync_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux8Meta_reg <= 1'b0;
      aux8Sync_reg <= 1'b0;
      aux4Meta_reg <= 1'b0;
      aux4Sync_reg <= 1'b0;
      sioMeta_reg <= 1'b0;
      sioSync_reg <= 1'b0;
    end else if (ce) begin
      aux8Meta_reg <= aux8In;
      aux8Sync_reg <= aux8Meta_reg;
      aux4Meta_reg <= aux4In;
      aux4Sync_reg <= aux4Meta_reg;
      sioMeta_reg <= sioIn;
      sioSync_reg <= sioMeta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------
  logic awHeld_reg, wHeld_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [7:0] wByte_reg;
  logic wLane_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wrGo;
  card_line_pkg::regSel_t wrSel;

  // Address and data are taken in either order; one write at a time.
  assign awready = ce & ~awHeld_reg & ~bvalid_reg;
  assign wready = ce & ~wHeld_reg & ~bvalid_reg;
  assign wrGo = ce & awHeld_reg & wHeld_reg & ~bvalid_reg;
  assign wrSel = decode(awAddr_reg);
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
    end else if (awvalid && awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= awaddr;
    end else if (wrGo) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wHeld_reg <= 1'b0;
      wByte_reg <= 8'h00;
      wLane_reg <= 1'b0;
    end else if (wvalid && wready) begin
      wHeld_reg <= 1'b1;
      wByte_reg <= wdata[7:0];
      wLane_reg <= wstrb[0];
    end else if (wrGo) begin
      wHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else if (wrGo) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wrSel == card_line_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (ce && bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic aux8Bit_reg, aux4Bit_reg;
  logic aux8Dir_reg, aux4Dir_reg;
  logic ioBit_reg, ioDir_reg;
  logic internal_clock_idle_level_reg, internal_clock_disable_reg;
  logic syncMode_reg, bypassMode_reg;
  logic wrInt, wrExt, wrDir, wrMode;

  // Only the low byte lane carries data; other lanes are ignored.
  assign wrInt = wrGo & wLane_reg & (wrSel == card_line_pkg::SEL_INT);
  assign wrExt = wrGo & wLane_reg & (wrSel == card_line_pkg::SEL_EXT);
  assign wrDir = wrGo & wLane_reg & (wrSel == card_line_pkg::SEL_DIR);
  assign wrMode = wrGo & wLane_reg & (wrSel == card_line_pkg::SEL_MODE);

  // Written bits are stored whatever the direction.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux8Bit_reg <= INT_RST[`INT_AUX8_BIT];
      aux4Bit_reg <= INT_RST[`INT_AUX4_BIT];
    end else if (wrInt) begin
      aux8Bit_reg <= wByte_reg[`INT_AUX8_BIT];
      aux4Bit_reg <= wByte_reg[`INT_AUX4_BIT];
    end
  end

  // Directions reset to input, so both aux lines float.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux8Dir_reg <= 1'b1;
      aux4Dir_reg <= 1'b1;
    end else if (wrDir) begin
      aux8Dir_reg <= wByte_reg[`DIR_AUX8_BIT];
      aux4Dir_reg <= wByte_reg[`DIR_AUX4_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncMode_reg <= 1'b0;
      bypassMode_reg <= 1'b0;
    end else if (wrMode) begin
      syncMode_reg <= wByte_reg[`MODE_SYNC_BIT];
      bypassMode_reg <= wByte_reg[`MODE_BYPASS_BIT];
    end
  end

  // External register clears to zero; unused bits are not stored.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ioBit_reg <= 1'b0;
      ioDir_reg <= 1'b0;
      internal_clock_idle_level_reg <= 1'b0;
      internal_clock_disable_reg <= 1'b0;
    end else if (wrExt) begin
      ioBit_reg <= wByte_reg[`EXT_IO_BIT];
      ioDir_reg <= wByte_reg[`EXT_IODIR_BIT];
      internal_clock_idle_level_reg <= wByte_reg[`EXT_INTERNAL_CLOCK_IDLE_LEVEL_BIT];
      internal_clock_disable_reg <= wByte_reg[`EXT_INTERNAL_CLOCK_DISABLE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Serial clock generation
  // ----------------------------------------------------------------------
  logic [CW-1:0] etuCnt_reg;
  logic etuClk_reg;
  logic sclk_reg;
  logic sclkNext;
  logic ioActive;
  logic ioCap_reg;

  // The line bits only act in bypass or synchronous mode.
  assign ioActive = bypassMode_reg | syncMode_reg;

  // The divider runs freely outside bypass; in synchronous mode it
  // is the source of the serial clock.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      etuCnt_reg <= '0;
      etuClk_reg <= 1'b0;
    end else if (ce) begin
      if (bypassMode_reg) begin
        etuCnt_reg <= '0;
        etuClk_reg <= 1'b0;
      end else if (etuCnt_reg == CW'(ETU_HALF - 1)) begin
        etuCnt_reg <= '0;
        etuClk_reg <= ~etuClk_reg;
      end else begin
        etuCnt_reg <= etuCnt_reg + 1'b1;
      end
    end
  end

  // Stopping is immediate, so firmware must park the line cleanly
  // around a clock stop; no stop or restart sequence is automated.
  // Bypass lets the level bit drive the line and ignores the disable bit.
  assign sclkNext = (bypassMode_reg | internal_clock_disable_reg) ? internal_clock_idle_level_reg : etuClk_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_reg <= 1'b0;
    end else if (ce) begin
      sclk_reg <= sclkNext;
    end
  end

  assign sclkOut = sclk_reg;

  // The I/O level is caught as the driven clock goes high.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ioCap_reg <= 1'b0;
    end else if (ce && syncMode_reg && sclkNext && !sclk_reg) begin
      ioCap_reg <= sioSync_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------
  logic aux8Out_reg, aux8Oe_reg;
  logic aux4Out_reg, aux4Oe_reg;
  logic sioOut_reg, sioOe_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux8Out_reg <= 1'b0;
      aux8Oe_reg <= 1'b0;
      aux4Out_reg <= 1'b0;
      aux4Oe_reg <= 1'b0;
      sioOut_reg <= 1'b0;
      sioOe_reg <= 1'b0;
    end else if (ce) begin
      aux8Out_reg <= aux8Bit_reg;
      aux8Oe_reg <= ~aux8Dir_reg;
      aux4Out_reg <= aux4Bit_reg;
      aux4Oe_reg <= ~aux4Dir_reg;
      sioOut_reg <= ioBit_reg;
      sioOe_reg <= ioActive & ~ioDir_reg;
    end
  end

  assign aux8Out = aux8Out_reg;
  assign aux8Oe = aux8Oe_reg;
  assign aux4Out = aux4Out_reg;
  assign aux4Oe = aux4Oe_reg;
  assign sioOut = sioOut_reg;
  assign sioOe = sioOe_reg;

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  logic rvalid_reg;
  logic [7:0] rByte_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rdByte;
  logic ioRead;
  card_line_pkg::regSel_t rdSel;

  assign arready = ce & ~rvalid_reg;
  assign rdSel = decode(araddr);

  // Input lines read the pin, outputs read the stored bit; outside bypass and sync mode the I/O line reads its stored bit.
  assign ioRead = (!ioActive || !ioDir_reg) ? ioBit_reg :
    (syncMode_reg ? ioCap_reg : sioSync_reg);

  always_comb begin
    rdByte = 8'h00;
    unique case (rdSel)
      card_line_pkg::SEL_INT: begin
        rdByte[`INT_AUX8_BIT] = aux8Dir_reg ? aux8Sync_reg : aux8Bit_reg;
        rdByte[`INT_AUX4_BIT] = aux4Dir_reg ? aux4Sync_reg : aux4Bit_reg;
      end
      card_line_pkg::SEL_EXT: begin
        rdByte[`EXT_IO_BIT] = ioRead;
        rdByte[`EXT_IODIR_BIT] = ioDir_reg;
        rdByte[`EXT_INTERNAL_CLOCK_IDLE_LEVEL_BIT] = internal_clock_idle_level_reg;
        rdByte[`EXT_INTERNAL_CLOCK_DISABLE_BIT] = internal_clock_disable_reg;
      end
      card_line_pkg::SEL_DIR: begin
        rdByte[`DIR_AUX8_BIT] = aux8Dir_reg;
        rdByte[`DIR_AUX4_BIT] = aux4Dir_reg;
      end
      card_line_pkg::SEL_MODE: begin
        rdByte[`MODE_SYNC_BIT] = syncMode_reg;
        rdByte[`MODE_BYPASS_BIT] = bypassMode_reg;
      end
      card_line_pkg::SEL_NONE: rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rByte_reg <= 8'h00;
      rresp_reg <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rByte_reg <= rdByte;
      rresp_reg <= (rdSel == card_line_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (ce && rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign rvalid = rvalid_reg;
  assign rdata = {24'h000000, rByte_reg};
  assign rresp = rresp_reg;

endmodule // card_line_ctrl

// file: card_line_ctrl_sva.sv
// Checker of the card line block's bus answers and pin relations.
`timescale 1ns/100ps
`include "card_line_cfg.svh"

module card_line_ctrl_sva #(
  parameter int ADDR_W = 18,
  parameter int ETU_HALF = `ETU_HALF_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic aux8Out,
  input wire logic aux8Oe,
  input wire logic aux4Out,
  input wire logic aux4Oe,
  input wire logic sioOe,
  input wire logic sclkOut
);
  localparam logic [ADDR_W-1:0] INT_A = ADDR_W'({`INT_CTL_IDX, 2'h0});
  localparam logic [ADDR_W-1:0] DIR_A = ADDR_W'({`DIR_CTL_IDX, 2'h0});
  localparam logic [ADDR_W-1:0] BAD_A = ADDR_W'(18'h3f834);
  logic bothIn;
  // The pin checks assume address and data are taken at one edge, as the bench offers them.
  assign bothIn = awvalid && awready && wvalid && wready && ce && wstrb[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_reset_lines_off: assert property ($past(rst) |-> !aux8Oe && !aux4Oe && !sioOe && !sclkOut)
    else $error("lines driven right after reset");
  a_write_answer: assert property (bothIn |-> ##2 bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready && ce |=> rvalid)
    else $error("read response late");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_unmapped_read: assert property (arvalid && arready && ce && araddr == BAD_A
      |=> rresp == `RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read answered");
  a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_busy_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  a_dir_to_oe: assert property (bothIn && awaddr == DIR_A |-> ##3
      aux8Oe == !$past(wdata[`DIR_AUX8_BIT], 3) && aux4Oe == !$past(wdata[`DIR_AUX4_BIT], 3))
    else $error("direction not applied");
  a_aux8_drive: assert property (bothIn && awaddr == INT_A |-> ##3 aux8Oe == $past(aux8Oe, 3)
      && (!aux8Oe || aux8Out == $past(wdata[`INT_AUX8_BIT], 3)))
    else $error("aux 8 drive wrong");
  a_aux4_drive: assert property (bothIn && awaddr == INT_A |-> ##3 aux4Oe == $past(aux4Oe, 3)
      && (!aux4Oe || aux4Out == $past(wdata[`INT_AUX4_BIT], 3)))
    else $error("aux 4 drive wrong");
endmodule // card_line_ctrl_sva

bind card_line_ctrl card_line_ctrl_sva #(.ADDR_W(ADDR_W), .ETU_HALF(ETU_HALF)) chk (
  .clk, .rst, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
  .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
  .aux8Out, .aux8Oe, .aux4Out, .aux4Oe, .sioOe, .sclkOut);

// file: card_line_ctrl_test.sv
// Self-checking bench for the card line block.
`timescale 1ns/100ps
`include "card_line_cfg.svh"

module card_line_ctrl_test;
  localparam logic [17:0] INT_A = {`INT_CTL_IDX, 2'h0};
  localparam logic [17:0] EXT_A = {`EXT_CTL_IDX, 2'h0};
  localparam logic [17:0] DIR_A = {`DIR_CTL_IDX, 2'h0};
  localparam logic [17:0] MODE_A = {`MODE_CTL_IDX, 2'h0};
  localparam logic [17:0] BAD_A = 18'h3f834;
  logic clk = 1'b0, rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [17:0] awaddr = 18'h0, araddr = 18'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic aux8In, aux8Out, aux8Oe, aux4In, aux4Out, aux4Oe, sioIn, sioOut, sioOe, sclkOut;
  logic drv8 = 1'b1, drv4 = 1'b0, drvSio = 1'b0;
  int fail_count = 0, cmp_count = 0, cycles = 0, n;

  always #5 clk = ~clk;

  card_line_ctrl #(.ADDR_W(18), .ETU_HALF(2)) uut (.clk, .rst, .ce(1'b1),
    .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .aux8In,
    .aux8Out, .aux8Oe, .aux4In, .aux4Out, .aux4Oe, .sioIn, .sioOut, .sioOe, .sclkOut);
  card_model card (.aux8Out, .aux8Oe, .aux4Out, .aux4Oe, .sioOut, .sioOe, .drv8, .drv4,
    .drvSio, .aux8In, .aux4In, .sioIn);

  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      ta = ta || awready === 1'b1;
      tw = tw || wready === 1'b1;
      awvalid <= !ta;
      wvalid <= !tw;
    end
    while (bvalid !== 1'b1) @(posedge clk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [17:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    // Ready follows the data by one edge, so the slave must hold its answer.
    while (rvalid !== 1'b1) @(posedge clk);
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
    chk(rdata, {24'h0, e});
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic toggles(input int cyc, output int t);
    logic p;
    t = 0;
    p = sclkOut;
    repeat (cyc) begin
      @(posedge clk);
      t += int'(sclkOut !== p);
      p = sclkOut;
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({29'h0, aux8Oe, aux4Oe, sioOe}, 32'h0);
    rd(DIR_A, 8'h0c, `RESP_OKAY);
    rd(EXT_A, 8'h00, `RESP_OKAY);
    rd(BAD_A, 8'h00, `RESP_SLVERR);
    wr(BAD_A, 8'hff, `RESP_SLVERR);
    wr(INT_A, 8'h04, `RESP_OKAY);
    repeat (4) @(posedge clk);
    chk({30'h0, aux8Oe, aux4Oe}, 32'h0);
    rd(INT_A, 8'h08, `RESP_OKAY);
    drv8 <= 1'b0;
    repeat (4) @(posedge clk);
    rd(INT_A, 8'h00, `RESP_OKAY);
    wr(DIR_A, 8'h00, `RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({28'h0, aux8Oe, aux4Oe, aux8Out, aux4Out}, 32'hd);
    wr(INT_A, 8'h08, `RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({28'h0, aux8Oe, aux4Oe, aux8Out, aux4Out}, 32'he);
    rd(INT_A, 8'h08, `RESP_OKAY);
    // Read at once: both aux lines are outputs, so the read shows the stored bits, not the pin.
    wr(INT_A, 8'h04, `RESP_OKAY);
    rd(INT_A, 8'h04, `RESP_OKAY);
    wr(EXT_A, 8'h03, `RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({31'h0, sclkOut}, 32'h1);
    wr(EXT_A, 8'h00, `RESP_OKAY);
    toggles(40, n);
    chk({31'h0, n >= 19 && n <= 21}, 32'h1);
    chk({31'h0, sioOe}, 32'h0);
    wr(MODE_A, 8'h01, `RESP_OKAY);
    wr(EXT_A, 8'h22, `RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({29'h0, sioOe, sioOut, sclkOut}, 32'h7);
    toggles(20, n);
    chk(n, 32'h0);
    wr(EXT_A, 8'hdf, `RESP_OKAY);
    drvSio <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, sioOe}, 32'h0);
    rd(EXT_A, 8'h33, `RESP_OKAY);
    wr(MODE_A, 8'h20, `RESP_OKAY);
    wr(EXT_A, 8'h10, `RESP_OKAY);
    repeat (20) @(posedge clk);
    wr(EXT_A, 8'h11, `RESP_OKAY);
    drvSio <= 1'b0;
    repeat (10) @(posedge clk);
    rd(EXT_A, 8'h31, `RESP_OKAY);
    wr(EXT_A, 8'h10, `RESP_OKAY);
    repeat (20) @(posedge clk);
    rd(EXT_A, 8'h10, `RESP_OKAY);
    close_out();
  end
endmodule // card_line_ctrl_test

// file: card_line_pkg.sv
// Types shared by the card line block.
package card_line_pkg;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_INT,
    SEL_EXT,
    SEL_DIR,
    SEL_MODE
  } regSel_t;

endpackage

// file: card_model.sv
// Behavioural card: drives each line itself whenever the block releases it.
`timescale 1ns/100ps

module card_model (
  input wire logic aux8Out,
  input wire logic aux8Oe,
  input wire logic aux4Out,
  input wire logic aux4Oe,
  input wire logic sioOut,
  input wire logic sioOe,
  input wire logic drv8,
  input wire logic drv4,
  input wire logic drvSio,
  output logic aux8In,
  output logic aux4In,
  output logic sioIn
);
  // The card holds every released line, so no level is left for the simulator to pick.
  assign aux8In = aux8Oe ? aux8Out : drv8;
  assign aux4In = aux4Oe ? aux4Out : drv4;
  assign sioIn = sioOe ? sioOut : drvSio;
endmodule // card_model
